// [hw/dscp_cfg.svh]
`ifndef DSCP_CFG_SVH
`define DSCP_CFG_SVH

// control word layout
`define DSCP_RW_POS 15
`define DSCP_IDX_HI 14
`define DSCP_IDX_LO 8
`define DSCP_DAT_HI 7
`define DSCP_DAT_LO 0
// shift counts of the word port
`define DSCP_SPI_HALF 5'h08
`define DSCP_SPI_LAST 5'h0f
`define DSCP_SPI_END 5'h10
// two-wire port
`define DSCP_BYTE_END 4'h8
`define DSCP_ADDR_FIXED 5'h13
`define DSCP_IDX_LAST 7'h7f
`define DSCP_IDX_FIRST 7'h00
`define DSCP_IDX_STEP 7'h01
// synchroniser lanes on the device side
`define DSCP_PIN_SEL 4
`define DSCP_PIN_CSN 3
`define DSCP_PIN_A1 2
`define DSCP_PIN_SCL 1
`define DSCP_PIN_SDA 0
// host controller registers and fields
`define DSCP_CSR_CTRL 4'h0
`define DSCP_CSR_WORD 4'h4
`define DSCP_CTRL_GO 0
`define DSCP_CTRL_RW 1
`define DSCP_CTRL_SEL 2
`define DSCP_CTRL_A0 3
`define DSCP_CTRL_A1 4
`define DSCP_STAT_BUSY 0
`define DSCP_STAT_NACK 1
// host item sequence
`define DSCP_IT_START 3'h0
`define DSCP_IT_ADDR 3'h1
`define DSCP_IT_INDEX 3'h2
`define DSCP_IT_WDATA 3'h3
`define DSCP_IT_RSTART 3'h3
`define DSCP_IT_RADDR 3'h4
`define DSCP_IT_RBYTE 3'h5
`define DSCP_IT_WSTOP 3'h4
`define DSCP_IT_RSTOP 3'h6
// link clock timing
`define DSCP_CLK_MHZ 100
`define DSCP_QTR_NS 640

`endif

// [hw/dscp_pkg.sv]
package dscp_pkg;

  typedef enum logic [5:0] {
    DSCP_I_IDLE = 6'h01,
    DSCP_I_ADDR = 6'h02,
    DSCP_I_RX = 6'h04,
    DSCP_I_SACK = 6'h08,
    DSCP_I_TX = 6'h10,
    DSCP_I_MACK = 6'h20
  } dscp_i2c_st_t;

  typedef enum logic [5:0] {
    DSCP_H_IDLE = 6'h01,
    DSCP_H_SPI = 6'h02,
    DSCP_H_START = 6'h04,
    DSCP_H_BYTE = 6'h08,
    DSCP_H_STOP = 6'h10,
    DSCP_H_GAP = 6'h20
  } dscp_host_st_t;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] spi_cnt;
    logic [15:0] spi_sh;
    logic spi_rd;
    logic [7:0] rb_sh;
    logic rb_o;
    logic rb_oe;
    dscp_i2c_st_t ist;
    logic [3:0] icnt;
    logic [7:0] ish;
    logic irw;
    logic ifirst;
    logic inc_pend;
    logic sda_oe;
    logic [6:0] idx;
    logic [7:0] wdat;
    logic we;
  } dscp_dev_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    dscp_host_st_t st;
    logic [15:0] tick;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [2:0] item;
    logic [15:0] sh;
    logic [7:0] rx;
    logic [15:0] word;
    logic [15:0] rdata;
    logic csn;
    logic scl;
    logic sda_o;
    logic rw;
    logic sel;
    logic a0;
    logic a1;
    logic busy;
    logic nack;
  } dscp_host_state_t;

endpackage

// [hw/dscp_if.sv]
`timescale 1ns/1ps
interface dscp_if;
  logic port_type_select;
  logic control_select_n;
  logic bus_addr_bit1;
  logic control_clock;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data_line;
  logic readback_o;
  logic readback_oe;
  logic readback_line;

  // wired-and with pull-up; a push-pull high only shows when nobody pulls low
  assign data_line = ~((host_data_oe & ~host_data_o) |
                       (dev_data_oe & ~dev_data_o));
  assign readback_line = readback_oe ? readback_o : 1'b1;

  modport dev (
    input port_type_select,
    input control_select_n,
    input bus_addr_bit1,
    input control_clock,
    input data_line,
    output dev_data_o,
    output dev_data_oe,
    output readback_o,
    output readback_oe
  );

  modport host (
    output port_type_select,
    output control_select_n,
    output bus_addr_bit1,
    output control_clock,
    output host_data_o,
    output host_data_oe,
    input data_line,
    input readback_line
  );
endinterface

// [hw/dscp_dev.sv]
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dscp_cfg.svh"
module dscp_dev (
  input wire logic clk,
  input wire logic rstn,
  dscp_if.dev link,
  output logic [6:0] register_index,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_defined
);

  dscp_pkg::dscp_dev_state_t q;
  dscp_pkg::dscp_dev_state_t n;

  function automatic logic [6:0] next_idx(input logic [6:0] i);
    if (i == `DSCP_IDX_LAST) begin
      next_idx = `DSCP_IDX_FIRST;
    end else begin
      next_idx = i + `DSCP_IDX_STEP;
    end
  endfunction

  logic spi_mode;
  logic csn;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] spi_ns;
  logic [6:0] own_addr;

  // only second and third stages feed logic; first stage is sync only
  assign spi_mode = ~q.s2[`DSCP_PIN_SEL];
  assign csn = q.s2[`DSCP_PIN_CSN];
  assign scl = q.s2[`DSCP_PIN_SCL];
  assign sda = q.s2[`DSCP_PIN_SDA];
  assign scl_rise = scl & ~q.s3[`DSCP_PIN_SCL];
  assign scl_fall = ~scl & q.s3[`DSCP_PIN_SCL];
  assign start_c = scl & q.s3[`DSCP_PIN_SCL] & ~sda & q.s3[`DSCP_PIN_SDA];
  assign stop_c = scl & q.s3[`DSCP_PIN_SCL] & sda & ~q.s3[`DSCP_PIN_SDA];
  assign spi_ns = {q.spi_sh[14:0], sda};
  // control select pin and A1 pin double as address bits
  assign own_addr = {`DSCP_ADDR_FIXED, q.s2[`DSCP_PIN_A1], csn};

  always_comb begin
    n = q;
    n.s1 = {link.port_type_select, link.control_select_n,
            link.bus_addr_bit1, link.control_clock, link.data_line};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.we = 1'b0;

    // word port: edges of its own clock drive all progress
    if (!spi_mode || csn) begin
      n.spi_cnt = 5'h00;
      n.rb_oe = 1'b0;
      n.rb_o = 1'b1;
    end else begin
      if (scl_rise && q.spi_cnt != `DSCP_SPI_END) begin
        n.spi_sh = spi_ns;
        n.spi_cnt = q.spi_cnt + 5'h01;
        if (q.spi_cnt == `DSCP_SPI_HALF - 5'h01) begin
          n.spi_rd = spi_ns[`DSCP_RW_POS - `DSCP_IDX_LO];
          n.idx = spi_ns[`DSCP_IDX_HI - `DSCP_IDX_LO:0];
        end
        if (q.spi_cnt == `DSCP_SPI_LAST && !q.spi_rd) begin
          n.we = 1'b1;
          n.wdat = spi_ns[`DSCP_DAT_HI:`DSCP_DAT_LO];
        end
      end
      // extra clocks after the sixteenth are ignored until select rises
      if (scl_fall && q.spi_rd && q.spi_cnt >= `DSCP_SPI_HALF &&
          q.spi_cnt != `DSCP_SPI_END) begin
        if (q.spi_cnt == `DSCP_SPI_HALF) begin
          n.rb_sh = reg_rdata;
          n.rb_o = reg_rdata[7];
          n.rb_oe = 1'b1;
        end else begin
          n.rb_sh = {q.rb_sh[6:0], 1'b1};
          n.rb_o = q.rb_sh[6];
        end
      end
    end

    // two-wire slave; sda is only ever released or pulled low
    if (spi_mode) begin
      n.ist = dscp_pkg::DSCP_I_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.ist = dscp_pkg::DSCP_I_ADDR;
      n.icnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.ist = dscp_pkg::DSCP_I_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.ist)
        dscp_pkg::DSCP_I_ADDR, dscp_pkg::DSCP_I_RX: begin
          if (q.icnt != `DSCP_BYTE_END) begin
            n.ish = {q.ish[6:0], sda};
            n.icnt = q.icnt + 4'h1;
          end
          // deferred step: lets the defined check see the new index
          if (q.ist == dscp_pkg::DSCP_I_RX && q.icnt == 4'h0 &&
              q.inc_pend) begin
            n.idx = next_idx(q.idx);
            n.inc_pend = 1'b0;
          end
        end
        dscp_pkg::DSCP_I_TX: begin
          n.icnt = q.icnt + 4'h1;
        end
        dscp_pkg::DSCP_I_MACK: begin
          if (sda) begin
            n.ist = dscp_pkg::DSCP_I_IDLE;
          end else begin
            n.idx = next_idx(q.idx);
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q.ist)
        dscp_pkg::DSCP_I_ADDR: begin
          if (q.icnt == `DSCP_BYTE_END) begin
            if (q.ish[7:1] == own_addr) begin
              n.sda_oe = 1'b1;
              n.irw = q.ish[0];
              n.ifirst = 1'b1;
              n.ist = dscp_pkg::DSCP_I_SACK;
              // a read right after a write starts at the written register
              if (q.ish[0]) begin
                n.inc_pend = 1'b0;
              end
            end else begin
              n.ist = dscp_pkg::DSCP_I_IDLE;
            end
          end
        end
        dscp_pkg::DSCP_I_RX: begin
          if (q.icnt == `DSCP_BYTE_END) begin
            n.ist = dscp_pkg::DSCP_I_SACK;
            n.ifirst = 1'b0;
            if (q.ifirst) begin
              n.idx = q.ish[6:0];
              n.inc_pend = 1'b0;
              n.sda_oe = 1'b1;
            end else if (reg_defined) begin
              n.we = 1'b1;
              n.wdat = q.ish;
              n.inc_pend = 1'b1;
              n.sda_oe = 1'b1;
            end else begin
              n.sda_oe = 1'b0;
            end
          end
        end
        dscp_pkg::DSCP_I_SACK: begin
          n.icnt = 4'h0;
          if (q.irw) begin
            n.ist = dscp_pkg::DSCP_I_TX;
            n.ish = reg_rdata;
            n.sda_oe = ~reg_rdata[7];
          end else begin
            n.ist = dscp_pkg::DSCP_I_RX;
            n.sda_oe = 1'b0;
          end
        end
        dscp_pkg::DSCP_I_TX: begin
          if (q.icnt == `DSCP_BYTE_END) begin
            n.sda_oe = 1'b0;
            n.ist = dscp_pkg::DSCP_I_MACK;
          end else begin
            n.ish = {q.ish[6:0], 1'b1};
            n.sda_oe = ~q.ish[6];
          end
        end
        dscp_pkg::DSCP_I_MACK: begin
          n.icnt = 4'h0;
          n.ish = reg_rdata;
          n.sda_oe = ~reg_rdata[7];
          n.ist = dscp_pkg::DSCP_I_TX;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{s1: 5'h1f, s2: 5'h1f, s3: 5'h1f, spi_cnt: 5'h00,
             spi_sh: 16'h0000, spi_rd: 1'b0, rb_sh: 8'hff, rb_o: 1'b1,
             rb_oe: 1'b0, ist: dscp_pkg::DSCP_I_IDLE, icnt: 4'h0,
             ish: 8'h00, irw: 1'b0, ifirst: 1'b0, inc_pend: 1'b0,
             sda_oe: 1'b0, idx: 7'h00, wdat: 8'h00, we: 1'b0};
    end else begin
      q <= n;
    end
  end

  // all link activity is resampled on clk before it writes
  assign register_index = q.idx;
  assign reg_wdata = q.wdat;
  assign reg_we = q.we;
  assign link.dev_data_o = 1'b0;
  assign link.dev_data_oe = q.sda_oe;
  assign link.readback_o = q.rb_o;
  assign link.readback_oe = q.rb_oe;

endmodule

// [hw/dscp_host.sv]
`timescale 1ns/1ps
`include "dscp_cfg.svh"
module dscp_host #(
  parameter int unsigned QTR_CYCLES = (`DSCP_QTR_NS * `DSCP_CLK_MHZ) / 1000
) (
  input wire logic clk,
  input wire logic rstn,
  dscp_if.host link,
  input wire logic [3:0] csr_addr,
  input wire logic [15:0] csr_wdata,
  input wire logic csr_wr,
  input wire logic csr_rd,
  output logic [15:0] csr_rdata
);

  dscp_pkg::dscp_host_state_t q;
  dscp_pkg::dscp_host_state_t n;

  // sets up the next packet item of a two-wire transfer
  function automatic dscp_pkg::dscp_host_state_t enter(
    input dscp_pkg::dscp_host_state_t s, input logic [2:0] it);
    logic [7:0] b;
    logic [6:0] sa;
    enter = s;
    sa = {`DSCP_ADDR_FIXED, s.a1, s.a0};
    b = 8'hff;
    enter.item = it;
    enter.bitn = 4'h0;
    if (it == `DSCP_IT_START || (s.rw && it == `DSCP_IT_RSTART)) begin
      enter.st = dscp_pkg::DSCP_H_START;
    end else if (it == (s.rw ? `DSCP_IT_RSTOP : `DSCP_IT_WSTOP)) begin
      enter.st = dscp_pkg::DSCP_H_STOP;
    end else begin
      enter.st = dscp_pkg::DSCP_H_BYTE;
      if (it == `DSCP_IT_ADDR) begin
        b = {sa, 1'b0};
      end else if (it == `DSCP_IT_INDEX) begin
        b = {1'b0, s.word[`DSCP_IDX_HI:`DSCP_IDX_LO]};
      end else if (!s.rw) begin
        b = s.word[`DSCP_DAT_HI:`DSCP_DAT_LO];
      end else if (it == `DSCP_IT_RADDR) begin
        b = {sa, 1'b1};
      end
    end
    enter.sh = {8'h00, b};
    enter.sda_o = (enter.st == dscp_pkg::DSCP_H_STOP) ? 1'b0 :
                  (enter.st == dscp_pkg::DSCP_H_BYTE) ? b[7] : 1'b1;
  endfunction

  logic step;
  logic sda_in;
  logic rb_in;
  logic last_slot;

  assign sda_in = q.s2[1];
  assign rb_in = q.s2[0];
  assign step = (q.tick == 16'(QTR_CYCLES - 1));
  assign last_slot = (q.bitn == 4'(`DSCP_BYTE_END));

  always_comb begin
    n = q;
    n.s1 = {link.data_line, link.readback_line};
    n.s2 = q.s1;
    n.rdata = 16'h0000;
    if (csr_rd) begin
      if (csr_addr == `DSCP_CSR_CTRL) begin
        n.rdata = {14'h0000, q.nack, q.busy};
      end else if (csr_addr == `DSCP_CSR_WORD) begin
        n.rdata = {q.word[15:8], q.rx};
      end
    end
    if (csr_wr && csr_addr == `DSCP_CSR_WORD) begin
      n.word = csr_wdata;
    end
    // mode and address pins only move while the link is idle
    if (csr_wr && csr_addr == `DSCP_CSR_CTRL && !q.busy) begin
      n.rw = csr_wdata[`DSCP_CTRL_RW];
      n.sel = csr_wdata[`DSCP_CTRL_SEL];
      n.a0 = csr_wdata[`DSCP_CTRL_A0];
      n.a1 = csr_wdata[`DSCP_CTRL_A1];
      if (csr_wdata[`DSCP_CTRL_GO]) begin
        n.busy = 1'b1;
        n.nack = 1'b0;
        n.tick = 16'h0000;
        n.qtr = 2'h0;
        if (csr_wdata[`DSCP_CTRL_SEL]) begin
          n = enter(n, `DSCP_IT_START);
        end else begin
          n.st = dscp_pkg::DSCP_H_SPI;
          n.csn = 1'b0;
          n.bitn = 4'h0;
          n.sh = q.word;
          n.sda_o = q.word[`DSCP_RW_POS];
        end
      end
    end else if (q.st != dscp_pkg::DSCP_H_IDLE) begin
      n.tick = step ? 16'h0000 : q.tick + 16'h0001;
      if (step) begin
        n.qtr = q.qtr + 2'h1;
        case (q.st)
          dscp_pkg::DSCP_H_SPI: begin
            // clock idles high: fall first so every bit gets its own rise
            if (q.qtr == 2'h0) begin
              n.scl = 1'b0;
            end else if (q.qtr == 2'h2) begin
              n.scl = 1'b1;
            end else if (q.qtr == 2'h3) begin
              // readback has long settled since the fall
              n.rx = {q.rx[6:0], rb_in};
              if (q.bitn == 4'hf) begin
                n.csn = 1'b1;
                n.st = dscp_pkg::DSCP_H_GAP;
              end else begin
                n.bitn = q.bitn + 4'h1;
                n.sh = {q.sh[14:0], 1'b0};
                n.sda_o = q.sh[14];
              end
            end
          end
          dscp_pkg::DSCP_H_START: begin
            if (q.qtr == 2'h0) begin
              n.scl = 1'b1;
            end else if (q.qtr == 2'h1) begin
              n.sda_o = 1'b0;
            end else if (q.qtr == 2'h2) begin
              n.scl = 1'b0;
            end else begin
              // built on n so a register access in this cycle is kept
              n = enter(n, q.item + 3'h1);
              n.qtr = 2'h0;
              n.tick = 16'h0000;
            end
          end
          dscp_pkg::DSCP_H_BYTE: begin
            if (q.qtr == 2'h0) begin
              n.scl = 1'b1;
            end else if (q.qtr == 2'h1) begin
              if (!last_slot) begin
                n.rx = {q.rx[6:0], sda_in};
              end else if (sda_in && !(q.rw &&
                           q.item == `DSCP_IT_RBYTE)) begin
                n.nack = 1'b1;
              end
            end else if (q.qtr == 2'h2) begin
              n.scl = 1'b0;
            end else if (last_slot) begin
              // a refused byte ends the packet at once
              n = enter(n, q.nack ? (q.rw ? `DSCP_IT_RSTOP : `DSCP_IT_WSTOP)
                                  : q.item + 3'h1);
              n.qtr = 2'h0;
              n.tick = 16'h0000;
            end else begin
              n.bitn = q.bitn + 4'h1;
              n.sh = {q.sh[14:0], 1'b1};
              // release for the ack slot; a read byte ends released (nack)
              n.sda_o = (q.bitn == 4'h7) ? 1'b1 : q.sh[6];
            end
          end
          dscp_pkg::DSCP_H_STOP: begin
            if (q.qtr == 2'h0) begin
              n.scl = 1'b1;
            end else if (q.qtr == 2'h1) begin
              n.sda_o = 1'b1;
            end else if (q.qtr == 2'h3) begin
              n.st = dscp_pkg::DSCP_H_IDLE;
              n.busy = 1'b0;
            end
          end
          dscp_pkg::DSCP_H_GAP: begin
            if (q.qtr == 2'h3) begin
              n.st = dscp_pkg::DSCP_H_IDLE;
              n.busy = 1'b0;
            end
          end
          default: begin
            n.st = dscp_pkg::DSCP_H_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{s1: 2'h3, s2: 2'h3, st: dscp_pkg::DSCP_H_IDLE, tick: 16'h0000,
             qtr: 2'h0, bitn: 4'h0, item: 3'h0, sh: 16'h0000, rx: 8'h00,
             word: 16'h0000, rdata: 16'h0000, csn: 1'b1, scl: 1'b1,
             sda_o: 1'b1, rw: 1'b0, sel: 1'b0, a0: 1'b0, a1: 1'b0,
             busy: 1'b0, nack: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign csr_rdata = q.rdata;
  assign link.port_type_select = q.sel;
  assign link.control_select_n = q.sel ? q.a0 : q.csn;
  assign link.bus_addr_bit1 = q.a1;
  assign link.control_clock = q.scl;
  assign link.host_data_o = q.sel ? 1'b0 : q.sda_o;
  assign link.host_data_oe = q.sel ? ~q.sda_o : 1'b1;

endmodule

// [verif/dscp_asserts.sv]
`timescale 1ns/1ps
module dscp_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic port_type_select,
  input wire logic control_select_n,
  input wire logic control_clock,
  input wire logic dev_data_oe,
  input wire logic readback_o,
  input wire logic readback_oe
);
  logic clk_q;
  logic [5:0] rise_q;
  logic [5:0] fall_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // link edges of the current word frame only; cleared between frames
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_q <= 1'b1;
      rise_q <= 6'h00;
      fall_q <= 6'h00;
    end else begin
      clk_q <= control_clock;
      if (control_select_n || port_type_select) begin
        rise_q <= 6'h00;
        fall_q <= 6'h00;
      end else begin
        if (control_clock && !clk_q) rise_q <= rise_q + 6'h01;
        if (!control_clock && clk_q) fall_q <= fall_q + 6'h01;
      end
    end
  end

  oe_release_a: assert property (
    $rose(control_select_n) && !port_type_select |-> ##[0:8] !readback_oe)
    else $error("readback kept after select high");
  read_eighth_a: assert property (
    $rose(readback_oe) |-> rise_q == 6'h08 && fall_q == 6'h09 &&
    !port_type_select)
    else $error("readback began at wrong clock");
  word_len_a: assert property (
    $rose(control_select_n) && !port_type_select && !$past(port_type_select)
    |-> rise_q == 6'h10)
    else $error("word frame not sixteen clocks");
  start_idle_a: assert property (
    $fell(control_select_n) && !port_type_select |-> control_clock)
    else $error("frame began with clock low");
  sel_gap_a: assert property (
    $rose(control_select_n) && !port_type_select |-> control_select_n [*4])
    else $error("select high too short");
  rb_on_low_a: assert property (
    readback_oe && $past(readback_oe) && $changed(readback_o)
    |-> !control_clock)
    else $error("readback moved while clock high");
  ack_on_low_a: assert property (
    $changed(dev_data_oe) |-> !control_clock)
    else $error("data drive moved while clock high");
  word_quiet_a: assert property (
    !port_type_select && !$past(port_type_select, 8) |-> !dev_data_oe)
    else $error("data line driven in word mode");
  ack_bound_a: assert property (
    $rose(dev_data_oe) |-> ##[1:200] !dev_data_oe)
    else $error("data line held too long");
  wire_no_rb_a: assert property (
    port_type_select && $past(port_type_select, 8) |-> !readback_oe)
    else $error("readback driven in two-wire mode");
endmodule

// [verif/dual_serial_control_port_test.sv]
`timescale 1ns/1ps
`include "dscp_cfg.svh"
module dual_serial_control_port_test;
  typedef struct packed {
    logic sel;
    logic a1;
    logic a0;
    logic rw;
    logic [6:0] idx;
    logic [7:0] dat;
    logic [7:0] exp;
    logic nack;
  } dscp_row_t;
  // sel, a1, a0, rw, index, data, read result, nack
  localparam dscp_row_t ROWS [8] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 7'h10, 8'ha5, 8'h00, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h1, 7'h10, 8'h00, 8'ha5, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h0, 7'h7f, 8'h3c, 8'h00, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h1, 7'h7f, 8'h00, 8'h3c, 1'h0},
    '{1'h1, 1'h0, 1'h1, 1'h0, 7'h11, 8'h5a, 8'h00, 1'h0},
    '{1'h1, 1'h1, 1'h0, 1'h1, 7'h11, 8'h00, 8'h5a, 1'h0},
    '{1'h1, 1'h1, 1'h1, 1'h0, 7'h05, 8'h77, 8'h00, 1'h1},
    '{1'h1, 1'h0, 1'h0, 1'h1, 7'h10, 8'h00, 8'ha5, 1'h0}
  };
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] csr_addr = 4'h0;
  logic [15:0] csr_wdata = 16'h0000;
  logic csr_wr = 1'b0;
  logic csr_rd = 1'b0;
  logic [15:0] csr_rdata;
  logic [6:0] register_index;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic [7:0] regs [128];
  logic [7:0] reg_rdata;
  logic reg_defined;
  int error_cnt = 0;
  int cmp_count = 0;
  logic sck_q = 1'b1;
  logic sda_q = 1'b1;
  logic [15:0] w_sh = 16'h0000;
  logic [15:0] w_seen = 16'h0000;
  logic [5:0] w_cnt = 6'h00;
  logic [5:0] c_seen = 6'h00;
  logic [7:0] i_sh = 8'h00;
  logic [3:0] i_cnt = 4'h8;

  dscp_if link();
  dscp_dev dscp_dev_i (.clk(clk), .rstn(rstn), .link(link),
    .register_index(register_index), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata), .reg_defined(reg_defined));
  dscp_host #(.QTR_CYCLES(4)) dscp_host_i (.clk(clk), .rstn(rstn),
    .link(link), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
    .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_rdata(csr_rdata));
  dscp_asserts dscp_asserts_i (.clk(clk), .rstn(rstn),
    .port_type_select(link.port_type_select),
    .control_select_n(link.control_select_n),
    .control_clock(link.control_clock), .dev_data_oe(link.dev_data_oe),
    .readback_o(link.readback_o), .readback_oe(link.readback_oe));

  initial forever #5 clk = ~clk;

  // register file stand-in: all 128 registers exist; only 0x10..0x1f are defined
  assign reg_rdata = regs[register_index];
  assign reg_defined = (register_index[6:4] === 3'h1);
  always @(posedge clk) if (reg_we) regs[register_index] <= reg_wdata;

  // wire watch: word bits at clock rise, first byte after each start
  always @(posedge clk) begin
    sck_q <= link.control_clock;
    sda_q <= link.data_line;
    if (link.control_select_n || link.port_type_select) begin
      if (w_cnt != 6'h00) begin
        w_seen <= w_sh;
        c_seen <= w_cnt;
      end
      w_cnt <= 6'h00;
    end else if (link.control_clock && !sck_q) begin
      w_sh <= {w_sh[14:0], link.data_line};
      w_cnt <= w_cnt + 6'h01;
    end
    if (link.port_type_select && link.control_clock) begin
      if (sda_q && !link.data_line) i_cnt <= 4'h0;
      else if (!sck_q && i_cnt != 4'h8) begin
        i_sh <= {i_sh[6:0], link.data_line};
        i_cnt <= i_cnt + 4'h1;
      end
    end
  end

  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task csr_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    csr_addr <= a;
    csr_wdata <= d;
    csr_wr <= 1'b1;
    @(posedge clk);
    csr_wr <= 1'b0;
  endtask

  task csr_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    csr_addr <= a;
    csr_rd <= 1'b1;
    @(posedge clk);
    csr_rd <= 1'b0;
    @(negedge clk);
    d = csr_rdata;
  endtask

  task wait_idle();
    logic [15:0] st;
    st = 16'h0001;
    for (int n = 0; n < 1500 && st[0] !== 1'b0; n++)
      csr_read(`DSCP_CSR_CTRL, st);
    if (st[0] !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH t=%0t transfer never ended", $time);
      summarize();
    end
  endtask

  task run_row(input dscp_row_t r);
    logic [15:0] d;
    logic [7:0] old;
    old = regs[r.idx];
    csr_write(`DSCP_CSR_WORD, {r.rw, r.idx, r.dat});
    csr_write(`DSCP_CSR_CTRL, {11'h000, r.a1, r.a0, r.sel, r.rw, 1'b1});
    wait_idle();
    csr_read(`DSCP_CSR_CTRL, d);
    check({15'h0000, d[1]}, {15'h0000, r.nack});
    if (r.rw) begin
      csr_read(`DSCP_CSR_WORD, d);
      check({8'h00, d[7:0]}, {8'h00, r.exp});
    end else begin
      check({8'h00, regs[r.idx]}, {8'h00, r.nack ? old : r.dat});
    end
    if (r.sel) begin
      check({8'h00, i_sh}, {13'h0013, r.a1, r.a0, r.rw});
    end else begin
      check({10'h000, c_seen}, 16'h0010);
      check(w_seen, {r.rw, r.idx, r.dat});
    end
  endtask

  initial begin
    logic [15:0] d;
    for (int i = 0; i < 128; i++) regs[i] = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({12'h000, link.control_select_n, link.control_clock,
           link.readback_line, link.data_line}, 16'h000f);
    csr_read(`DSCP_CSR_CTRL, d);
    check(d, 16'h0000);
    foreach (ROWS[i]) run_row(ROWS[i]);
    // a second go while busy must not switch the port mid-word
    csr_write(`DSCP_CSR_WORD, {1'b0, 7'h12, 8'h11});
    csr_write(`DSCP_CSR_CTRL, 16'h0001);
    csr_write(`DSCP_CSR_CTRL, 16'h0007);
    @(negedge clk);
    check({15'h0000, link.port_type_select}, 16'h0000);
    wait_idle();
    check({8'h00, regs[7'h12]}, 16'h0011);
    check(w_seen, {1'b0, 7'h12, 8'h11});
    // reset in mid-read: link drops to idle at once, then recovers
    csr_write(`DSCP_CSR_WORD, {1'b1, 7'h10, 8'h00});
    csr_write(`DSCP_CSR_CTRL, 16'h0003);
    repeat (160) @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check({15'h0000, link.readback_line}, 16'h0001);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({11'h000, reg_we, link.control_select_n, link.control_clock,
           link.readback_line, link.data_line}, 16'h000f);
    check({9'h000, register_index}, 16'h0000);
    run_row(ROWS[1]);
    csr_read(4'h8, d);
    check(d, 16'h0000);
    summarize();
  end
endmodule
